// ===== logic/strap_regs_pkg.sv
// Constants shared by the strap status and override register bank
package strap_regs_pkg;

    // Standard management register numbers of the portal pair, and the device address of this bank
    localparam logic [4:0] REG_PORTAL_CTRL = 5'h0d; // Portal control
    localparam logic [4:0] REG_PORTAL_DATA = 5'h0e; // Portal address/data
    localparam logic [4:0] DEV_VENDOR = 5'h02; // Device address of this bank

    // Indirect register addresses inside the vendor device
    localparam logic [15:0] MMD_COMMON_CONTROL = 16'h0000; // Common control
    localparam logic [15:0] MMD_STRAP_STATUS = 16'h0001; // Strap status
    localparam logic [15:0] MMD_OP_MODE_OVERRIDE = 16'h0002; // Op mode override

    // Field positions
    localparam int PORTAL_OP_HI = 15; // Operation field, upper bit
    localparam int PORTAL_OP_LO = 14; // Operation field, lower bit
    localparam int PORTAL_DEV_HI = 4; // Device address field, upper bit
    localparam int CC_LED_OVR_BIT = 4; // LED style override, write-only
    localparam int CC_LED_STATUS_BIT = 3; // LED style in force
    localparam int CC_REF_CLK_BIT = 1; // Reference clock output enable
    localparam int SS_LED_STRAP_BIT = 7; // LED style strap as latched
    localparam int SS_REF_CLK_STRAP_BIT = 5; // Ref clock strap as latched
    localparam int OM_WAKE_EN_BIT = 10; // Wake event output enable

    // Reset values
    localparam logic [15:0] PORTAL_CTRL_RESET = 16'h0000; // Portal control
    localparam logic [15:0] PORTAL_DATA_RESET = 16'h0000; // Portal address
    localparam logic [15:0] CC_RESERVED_RESET = 16'h0000; // Reserved RW bits
    localparam logic [15:0] OM_RESET = 16'h0000; // Op mode override
    localparam logic [15:0] RDATA_RESET = 16'h0000; // Read data output

    // Strap pin synchroniser depth
    localparam int STRAP_SYNC_STAGES = 3; // Three flops per strap pin

    // Meaning of portal data accesses
    typedef enum logic [1:0] {
        OP_ADDRESS = 2'b00,
        OP_DATA_HOLD = 2'b01,
        OP_DATA_INC_RW = 2'b10,
        OP_DATA_INC_WR = 2'b11
    } portal_op_t;

endpackage

// ===== logic/strap_pin_sync.sv
// Three-flop synchroniser for a group of strap pins with agreement flag
`timescale 1ns/1ps
module strap_pin_sync #(
    parameter int WIDTH = 5 // Number of strap pins
) (
    input wire logic clk_in, // System clock
    input wire logic rst_n_in, // Synchronous reset, active low
    input wire logic ce_in, // Clock enable
    input wire logic [WIDTH-1:0] pin_in, // Raw strap pins
    output logic [WIDTH-1:0] level_out, // Third-stage level
    output logic agree_out // Second and third stage agree on every bit
);
    import strap_regs_pkg::*;

    logic [WIDTH-1:0] stage [STRAP_SYNC_STAGES]; // Synchroniser chain
    logic [WIDTH-1:0] bit_agree; // Per-bit agreement of stages two and three

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_pin
            // Chain of three flops per pin; stage 0 feeds only stage 1
            always_ff @(posedge clk_in) begin
                if (!rst_n_in) begin
                    stage[0][i] <= 1'b0;
                    stage[1][i] <= 1'b0;
                    stage[2][i] <= 1'b0;
                end else if (ce_in) begin
                    stage[0][i] <= pin_in[i];
                    stage[1][i] <= stage[0][i];
                    stage[2][i] <= stage[1][i];
                end
            end
            assign bit_agree[i] = (stage[1][i] == stage[2][i]);
        end
    endgenerate

    // A level counts only once two later stages agree
    assign level_out = stage[2];
    assign agree_out = &bit_agree;

endmodule

// ===== logic/strap_override_status_regs.sv
// Strap status and override register bank behind the portal register pair
//
// Function
// - LED override bit is write-only, reads zero
// - Override one selects single-LED, zero tri-color
// - LED status bit: strap at reset, then override
// - Reference clock enable override, strap reset value
// - Latched LED strap reported read-only, never overridden
// - Latched reference clock strap reported read-only
// - Strapped address in bits 2:0, upper zero
// - Reserved strap status bits read as zero
// - Wake event output enable bit, reset zero
// - Portal operation field selects address or data
`timescale 1ns/1ps
module strap_override_status_regs (
    input wire logic CLK_IN, // System clock, 100 MHz
    input wire logic RST_N_IN, // Synchronous reset, active low
    input wire logic CE_IN, // Clock enable, freezes state when low
    input wire logic MGMT_WR_IN, // Management register write strobe
    input wire logic MGMT_RD_IN, // Management register read strobe
    input wire logic [4:0] MGMT_REG_IN, // Management register number
    input wire logic [15:0] MGMT_WDATA_IN, // Management write data
    input wire logic STRAP_LED_STYLE_IN, // LED style strap pin
    input wire logic STRAP_REF_CLK_EN_IN, // Ref clock output enable strap pin
    input wire logic [2:0] STRAP_ADDR_IN, // Station address strap pins
    output logic [15:0] MGMT_RDATA_OUT, // Read data, held until next read
    output logic MGMT_RVALID_OUT, // Read data valid, one-cycle pulse
    output logic LED_STYLE_SELECT_OUT, // LED style in force, 1 single-LED
    output logic REF_CLOCK_OUTPUT_ENABLE_OUT, // Reference clock output enable
    output logic WAKE_EVENT_OUTPUT_EN_OUT, // Wake event output enable
    output logic [4:0] STRAPPED_STATION_ADDRESS_OUT, // Five-bit station address
    output logic STRAP_DONE_OUT // Straps latched
);
    import strap_regs_pkg::*;

    // Strap capture sequence
    typedef enum logic {WAIT_STRAP, RUN} strap_state_t;

    strap_state_t state; // Capture state
    logic [15:0] portal_ctrl; // Portal control register
    logic [15:0] mmd_addr; // Indirect register address
    logic [15:0] cc_store; // Reserved RW bits of common control
    logic [15:0] om_reg; // Op mode override register
    logic led_style; // LED style in force
    logic ref_clk; // Reference clock enable in force
    logic strap_led; // Latched LED strap
    logic strap_ref; // Latched ref clock strap
    logic [2:0] strap_addr; // Latched address strap
    logic [4:0] sync_level; // Synchronised strap levels
    logic sync_agree; // Synchronised levels are stable
    logic [1:0] fill_cnt; // Edges since release while the chain fills

    // Strap pins come from outside the clock domain
    strap_pin_sync #(
        .WIDTH(5)
    ) u_sync (
        .clk_in(CLK_IN),
        .rst_n_in(RST_N_IN),
        .ce_in(CE_IN),
        .pin_in({STRAP_ADDR_IN, STRAP_REF_CLK_EN_IN, STRAP_LED_STYLE_IN}),
        .level_out(sync_level),
        .agree_out(sync_agree)
    );

    // Decode of one indirect register in this bank
    function automatic logic mmd_sel(input logic [4:0] dev, input logic [15:0] addr,
                                     input logic [15:0] target);
        mmd_sel = (dev == DEV_VENDOR) && (addr == target);
    endfunction

    // Access decode
    wire portal_op_t op = portal_op_t'(portal_ctrl[PORTAL_OP_HI:PORTAL_OP_LO]);
    wire [4:0] dev = portal_ctrl[PORTAL_DEV_HI:0];
    wire data_phase = (op != OP_ADDRESS);
    wire wr_ctrl = CE_IN && MGMT_WR_IN && (MGMT_REG_IN == REG_PORTAL_CTRL);
    wire wr_data = CE_IN && MGMT_WR_IN && (MGMT_REG_IN == REG_PORTAL_DATA);
    wire rd_any = CE_IN && MGMT_RD_IN;
    wire rd_data = rd_any && (MGMT_REG_IN == REG_PORTAL_DATA);
    wire sel_cc = mmd_sel(dev, mmd_addr, MMD_COMMON_CONTROL);
    wire sel_ss = mmd_sel(dev, mmd_addr, MMD_STRAP_STATUS);
    wire sel_om = mmd_sel(dev, mmd_addr, MMD_OP_MODE_OVERRIDE);
    wire mmd_wr = wr_data && data_phase;
    wire cc_wr = mmd_wr && sel_cc;
    wire om_wr = mmd_wr && sel_om;
    // Reset zeros in the chain agree too; wait until they have left it
    wire chain_full = (fill_cnt == 2'(STRAP_SYNC_STAGES));
    wire capture = (state == WAIT_STRAP) && CE_IN && chain_full && sync_agree;

    // Post increment: writes in both increment modes, reads in one
    wire addr_inc = (mmd_wr && (op == OP_DATA_INC_RW || op == OP_DATA_INC_WR))
                 || (rd_data && op == OP_DATA_INC_RW);
    wire [15:0] next_mmd_addr = addr_inc ? 16'(mmd_addr + 16'h0001) : mmd_addr;

    // Read images; override bit and reserved strap bits read zero
    wire [15:0] cc_read = {cc_store[15:5], 1'b0, led_style, cc_store[2],
                           ref_clk, cc_store[0]};
    wire [15:0] ss_read = {8'h00, strap_led, 1'b0, strap_ref, 2'b00,
                           strap_addr};
    wire [15:0] mmd_read = sel_cc ? cc_read : sel_ss ? ss_read : sel_om ? om_reg : 16'h0000;
    wire [15:0] next_rdata = (MGMT_REG_IN == REG_PORTAL_CTRL) ? portal_ctrl :
                             (MGMT_REG_IN == REG_PORTAL_DATA) ?
                             (data_phase ? mmd_read : mmd_addr) : 16'h0000;

    // Count edges until the chain holds real pin samples
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            fill_cnt <= 2'h0;
        end else if (CE_IN && !chain_full) begin
            fill_cnt <= fill_cnt + 2'h1;
        end
    end

    // Strap capture after reset release, once the pins are stable
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            state <= WAIT_STRAP;
        end else if (capture) begin
            state <= RUN;
        end
    end

    // Latched strap values; nothing software does reaches them
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            strap_led <= 1'b0;
            strap_ref <= 1'b0;
            strap_addr <= 3'h0;
        end else if (capture) begin
            strap_led <= sync_level[0];
            strap_ref <= sync_level[1];
            strap_addr <= sync_level[4:2];
        end
    end

    // Portal registers; the controller selects device and register first
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            portal_ctrl <= PORTAL_CTRL_RESET;
            mmd_addr <= PORTAL_DATA_RESET;
        end else begin
            if (wr_ctrl) begin
                portal_ctrl <= MGMT_WDATA_IN;
            end
            if (wr_data && !data_phase) begin
                mmd_addr <= MGMT_WDATA_IN;
            end else begin
                mmd_addr <= next_mmd_addr;
            end
        end
    end

    // LED style: strap first, a later write wins over the capture
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            led_style <= 1'b0;
        end else if (cc_wr) begin
            led_style <= MGMT_WDATA_IN[CC_LED_OVR_BIT];
        end else if (capture) begin
            led_style <= sync_level[0];
        end
    end

    // Reference clock enable: strap first, then software override
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            ref_clk <= 1'b0;
        end else if (cc_wr) begin
            ref_clk <= MGMT_WDATA_IN[CC_REF_CLK_BIT];
        end else if (capture) begin
            ref_clk <= sync_level[1];
        end
    end

    // Reserved RW bits of common control and the op mode register
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            cc_store <= CC_RESERVED_RESET;
            om_reg <= OM_RESET;
        end else begin
            if (cc_wr) begin
                cc_store <= MGMT_WDATA_IN;
            end
            if (om_wr) begin
                om_reg <= MGMT_WDATA_IN;
            end
        end
    end

    // Read answer, registered; every read strobe taken while the clock enable is high is answered
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            MGMT_RDATA_OUT <= RDATA_RESET;
            MGMT_RVALID_OUT <= 1'b0;
        end else if (CE_IN) begin
            MGMT_RVALID_OUT <= MGMT_RD_IN;
            if (MGMT_RD_IN) begin
                MGMT_RDATA_OUT <= next_rdata;
            end
        end
    end

    // Outputs straight from flops; upper address bits are fixed zero
    assign LED_STYLE_SELECT_OUT = led_style;
    assign REF_CLOCK_OUTPUT_ENABLE_OUT = ref_clk;
    assign WAKE_EVENT_OUTPUT_EN_OUT = om_reg[OM_WAKE_EN_BIT];
    assign STRAPPED_STATION_ADDRESS_OUT = {2'b00, strap_addr};
    assign STRAP_DONE_OUT = (state == RUN);

    // Checks on the register behaviour
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    sequence s_cc_read;
        rd_data && data_phase && sel_cc;
    endsequence
    sequence s_ss_read;
        rd_data && data_phase && sel_ss;
    endsequence

    property p_led_ovr_reads_zero;
        s_cc_read |=> MGMT_RVALID_OUT && !MGMT_RDATA_OUT[CC_LED_OVR_BIT];
    endproperty
    a_led_ovr_reads_zero: assert property (p_led_ovr_reads_zero)
        else $error("LED override bit did not read zero");

    property p_led_write_live;
        cc_wr |=> LED_STYLE_SELECT_OUT == $past(MGMT_WDATA_IN[CC_LED_OVR_BIT]);
    endproperty
    a_led_write_live: assert property (p_led_write_live)
        else $error("LED style did not follow override write");

    property p_led_status_mirror;
        cc_wr ##1 !cc_wr ##1 s_cc_read |=> MGMT_RDATA_OUT[CC_LED_STATUS_BIT]
            == $past(MGMT_WDATA_IN[CC_LED_OVR_BIT], 3);
    endproperty
    a_led_status_mirror: assert property (p_led_status_mirror)
        else $error("LED status bit did not show last override");

    property p_ref_clk_write;
        cc_wr |=> REF_CLOCK_OUTPUT_ENABLE_OUT == $past(MGMT_WDATA_IN[CC_REF_CLK_BIT]);
    endproperty
    a_ref_clk_write: assert property (p_ref_clk_write)
        else $error("Reference clock enable did not follow write");

    property p_strap_fixed;
        (state == RUN) |=> $stable(strap_led) && $stable(strap_ref) && $stable(strap_addr);
    endproperty
    a_strap_fixed: assert property (p_strap_fixed)
        else $error("Latched strap changed after capture");

    property p_strap_status_read;
        s_ss_read |=> MGMT_RDATA_OUT[2:0] == $past(strap_addr)
            && MGMT_RDATA_OUT[SS_REF_CLK_STRAP_BIT] == $past(strap_ref)
            && MGMT_RDATA_OUT[SS_LED_STRAP_BIT] == $past(strap_led);
    endproperty
    a_strap_status_read: assert property (p_strap_status_read)
        else $error("Strap status read does not match latched straps");

    property p_strap_reserved_zero;
        s_ss_read |=> MGMT_RDATA_OUT[15:8] == 8'h00 && !MGMT_RDATA_OUT[6]
            && MGMT_RDATA_OUT[4:3] == 2'b00;
    endproperty
    a_strap_reserved_zero: assert property (p_strap_reserved_zero)
        else $error("Reserved strap status bits not zero");

    property p_wake_enable;
        om_wr |=> WAKE_EVENT_OUTPUT_EN_OUT == $past(MGMT_WDATA_IN[OM_WAKE_EN_BIT]);
    endproperty
    a_wake_enable: assert property (p_wake_enable)
        else $error("Wake enable did not follow write");

    property p_post_inc;
        addr_inc |=> mmd_addr == 16'($past(mmd_addr) + 16'h0001);
    endproperty
    a_post_inc: assert property (p_post_inc)
        else $error("Indirect address did not post increment");

    property p_no_inc_hold;
        (rd_data || wr_data) && op == OP_DATA_HOLD |=> $stable(mmd_addr);
    endproperty
    a_no_inc_hold: assert property (p_no_inc_hold)
        else $error("Indirect address moved without increment mode");

endmodule

// ===== dv/mgmt_ctrl_model.sv
// Station management controller model driving the portal register pair
`timescale 1ns/1ps
module mgmt_ctrl_model (
    input wire logic clk_in, // System clock
    input wire logic [15:0] rdata_in, // Read data from the bank
    input wire logic rvalid_in, // Read data valid pulse
    output logic wr_out, // Write strobe
    output logic rd_out, // Read strobe
    output logic [4:0] reg_out, // Register number
    output logic [15:0] wdata_out // Write data
);
    import strap_regs_pkg::*;
    int gap = 0; // Idle cycles before each access, for slow pacing
    // Idle bus at time zero
    initial begin
        wr_out = 1'b0;
        rd_out = 1'b0;
        reg_out = 5'h1f;
        wdata_out = 16'hffff;
    end
    // One write; released lines invert so stale values never look valid
    task automatic write_reg(input logic [4:0] r, input logic [15:0] d);
        repeat (gap) @(posedge clk_in);
        @(posedge clk_in);
        wr_out <= 1'b1;
        reg_out <= r;
        wdata_out <= d;
        @(posedge clk_in);
        wr_out <= 1'b0;
        reg_out <= ~r;
        wdata_out <= ~d;
    endtask
    // One read; data taken with the valid pulse, bounded wait
    task automatic read_reg(input logic [4:0] r, output logic [15:0] d);
        logic ok;
        ok = 1'b0;
        d = 16'hxxxx;
        repeat (gap) @(posedge clk_in);
        @(posedge clk_in);
        rd_out <= 1'b1;
        reg_out <= r;
        @(posedge clk_in);
        rd_out <= 1'b0;
        reg_out <= ~r;
        for (int i = 0; i < 4 && !ok; i++) begin
            #1;
            if (rvalid_in === 1'b1) begin
                d = rdata_in;
                ok = 1'b1;
            end else begin
                @(posedge clk_in);
            end
        end
    endtask
    // Device, address, then operation through the portal pair
    task automatic mmd_set(input logic [4:0] dev, input logic [15:0] a, input logic [1:0] op);
        write_reg(REG_PORTAL_CTRL, {2'b00, 9'h000, dev});
        write_reg(REG_PORTAL_DATA, a);
        write_reg(REG_PORTAL_CTRL, {op, 9'h000, dev});
    endtask
endmodule

// ===== dv/tb.sv
// Self-checking bench for the strap status and override register bank
`timescale 1ns/1ps
module tb;
    import strap_regs_pkg::*;
    localparam logic LED_STRAP = 1'b1; // Single-LED strapped
    localparam logic REF_STRAP = 1'b1; // Reference clock strapped on
    localparam logic [2:0] ADDR_STRAP = 3'h5; // Strapped station address
    logic CLK_IN = 1'b0;
    logic RST_N_IN = 1'b0;
    logic ce = 1'b1;
    logic wr, rd, rvalid, led, refclk, wake, done;
    logic [4:0] regno, addr;
    logic [15:0] wdata, rdata, d;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    // 100 MHz clock
    always #5 CLK_IN = ~CLK_IN;
    strap_override_status_regs strap_override_status_regs_inst (
        .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .CE_IN(ce),
        .MGMT_WR_IN(wr), .MGMT_RD_IN(rd), .MGMT_REG_IN(regno), .MGMT_WDATA_IN(wdata),
        .STRAP_LED_STYLE_IN(LED_STRAP), .STRAP_REF_CLK_EN_IN(REF_STRAP),
        .STRAP_ADDR_IN(ADDR_STRAP), .MGMT_RDATA_OUT(rdata), .MGMT_RVALID_OUT(rvalid),
        .LED_STYLE_SELECT_OUT(led), .REF_CLOCK_OUTPUT_ENABLE_OUT(refclk),
        .WAKE_EVENT_OUTPUT_EN_OUT(wake), .STRAPPED_STATION_ADDRESS_OUT(addr),
        .STRAP_DONE_OUT(done));
    mgmt_ctrl_model mgmt_ctrl_model_inst (
        .clk_in(CLK_IN), .rdata_in(rdata), .rvalid_in(rvalid), .wr_out(wr),
        .rd_out(rd), .reg_out(regno), .wdata_out(wdata));
    // Compare and count
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Closing report
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Let a write land on the outputs
    task automatic settle();
        @(posedge CLK_IN);
        #1;
    endtask
    // Strap values after reset, at pins and in both registers
    task automatic t_reset_straps();
        check({11'h0, addr}, {2'b00, ADDR_STRAP});
        check({14'h0, led, refclk}, {14'h0, LED_STRAP, REF_STRAP});
        check({15'h0, wake}, 16'h0000);
        mgmt_ctrl_model_inst.mmd_set(DEV_VENDOR, MMD_COMMON_CONTROL, OP_DATA_INC_RW);
        mgmt_ctrl_model_inst.read_reg(REG_PORTAL_DATA, d);
        check(d, {12'h000, LED_STRAP, 1'b0, REF_STRAP, 1'b0});
        mgmt_ctrl_model_inst.read_reg(REG_PORTAL_DATA, d);
        check(d, {8'h00, LED_STRAP, 1'b0, REF_STRAP, 2'b00, ADDR_STRAP});
        mgmt_ctrl_model_inst.read_reg(REG_PORTAL_DATA, d);
        check(d, 16'h0000);
    endtask
    // Overrides act at once; write-only bit reads zero; strap status untouched
    task automatic t_overrides();
        mgmt_ctrl_model_inst.mmd_set(DEV_VENDOR, MMD_COMMON_CONTROL, OP_DATA_HOLD);
        mgmt_ctrl_model_inst.write_reg(REG_PORTAL_DATA, 16'h0000);
        settle();
        check({14'h0, led, refclk}, 16'h0000);
        mgmt_ctrl_model_inst.read_reg(REG_PORTAL_DATA, d);
        check(d, 16'h0000);
        mgmt_ctrl_model_inst.write_reg(REG_PORTAL_DATA, 16'hffff);
        settle();
        check({14'h0, led, refclk}, 16'h0003);
        mgmt_ctrl_model_inst.read_reg(REG_PORTAL_DATA, d);
        check(d, 16'hffef);
        mgmt_ctrl_model_inst.write_reg(REG_PORTAL_DATA, 16'h0012);
        mgmt_ctrl_model_inst.read_reg(REG_PORTAL_DATA, d);
        check(d, 16'h000a);
        mgmt_ctrl_model_inst.mmd_set(DEV_VENDOR, MMD_STRAP_STATUS, OP_DATA_HOLD);
        mgmt_ctrl_model_inst.write_reg(REG_PORTAL_DATA, 16'hffff);
        mgmt_ctrl_model_inst.read_reg(REG_PORTAL_DATA, d);
        check(d, {8'h00, LED_STRAP, 1'b0, REF_STRAP, 2'b00, ADDR_STRAP});
        check({11'h0, addr}, {2'b00, ADDR_STRAP});
    endtask
    // Write-increment mode reaches the wake enable; slow pacing here
    task automatic t_wake_and_modes();
        mgmt_ctrl_model_inst.gap = 2;
        mgmt_ctrl_model_inst.mmd_set(DEV_VENDOR, MMD_STRAP_STATUS, OP_DATA_INC_WR);
        mgmt_ctrl_model_inst.write_reg(REG_PORTAL_DATA, 16'h1234);
        mgmt_ctrl_model_inst.write_reg(REG_PORTAL_DATA, 16'h0400);
        settle();
        check({15'h0, wake}, 16'h0001);
        mgmt_ctrl_model_inst.gap = 0;
        mgmt_ctrl_model_inst.read_reg(REG_PORTAL_DATA, d);
        check(d, 16'h0000);
        mgmt_ctrl_model_inst.write_reg(REG_PORTAL_CTRL, 16'h0002);
        mgmt_ctrl_model_inst.read_reg(REG_PORTAL_DATA, d);
        check(d, 16'h0003);
        mgmt_ctrl_model_inst.read_reg(REG_PORTAL_CTRL, d);
        check(d, 16'h0002);
        mgmt_ctrl_model_inst.mmd_set(DEV_VENDOR, MMD_OP_MODE_OVERRIDE, OP_DATA_HOLD);
        mgmt_ctrl_model_inst.read_reg(REG_PORTAL_DATA, d);
        check(d, 16'h0400);
        mgmt_ctrl_model_inst.read_reg(REG_PORTAL_DATA, d);
        check(d, 16'h0400);
        mgmt_ctrl_model_inst.write_reg(REG_PORTAL_DATA, 16'h0000);
        settle();
        check({15'h0, wake}, 16'h0000);
        mgmt_ctrl_model_inst.mmd_set(5'h03, MMD_COMMON_CONTROL, OP_DATA_HOLD);
        mgmt_ctrl_model_inst.read_reg(REG_PORTAL_DATA, d);
        check(d, 16'h0000);
        mgmt_ctrl_model_inst.read_reg(5'h00, d);
        check(d, 16'h0000);
    endtask
    // A write while the clock enable is low must not land
    task automatic t_clock_enable();
        mgmt_ctrl_model_inst.mmd_set(DEV_VENDOR, MMD_OP_MODE_OVERRIDE, OP_DATA_HOLD);
        @(posedge CLK_IN);
        ce <= 1'b0;
        mgmt_ctrl_model_inst.write_reg(REG_PORTAL_DATA, 16'h0400);
        @(posedge CLK_IN);
        ce <= 1'b1;
        settle();
        check({15'h0, wake}, 16'h0000);
        mgmt_ctrl_model_inst.read_reg(REG_PORTAL_DATA, d);
        check(d, 16'h0000);
    endtask
    // Cycle ceiling against hangs
    always @(posedge CLK_IN) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            tally_and_finish();
        end
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge CLK_IN);
        RST_N_IN <= 1'b1;
        for (int i = 0; i < 20 && done !== 1'b1; i++) @(posedge CLK_IN);
        #1;
        check({15'h0, done}, 16'h0001);
        t_reset_straps();
        t_overrides();
        t_wake_and_modes();
        t_clock_enable();
        tally_and_finish();
    end
endmodule
